//--- vcp_sysregs.v
// Virtual group 1 active priority and group 0 binary point system registers.
`timescale 1ns/1ps
`default_nettype none
`include "vcp_map.vh"

module vcp_sysregs #(
  parameter integer PRIORITY_BIT_COUNT = `VCP_PRI_BITS_DEFAULT
) (
  // Clock, reset and enable.
  input  wire        CLOCK,
  input  wire        SYS_RST,
  input  wire        CE,
  // System register access from the core.
  input  wire        ACC_VALID,
  input  wire        ACC_WRITE,
  input  wire [2:0]  ACC_OPC1,
  input  wire [2:0]  ACC_OPC2,
  input  wire [3:0]  ACC_CRN,
  input  wire [3:0]  ACC_CRM,
  input  wire [3:0]  ACC_COPROC,
  input  wire [1:0]  ACC_EL,
  input  wire [31:0] ACC_WDATA,
  // Routing and trap controls from the core.
  input  wire        NONSECURE_SELECT,
  input  wire        IRQ_ROUTE_TO_HYP,
  input  wire        FIQ_ROUTE_TO_HYP,
  input  wire        TRAP_GENERAL_TO_HYP,
  input  wire        SYSREG_IFACE_ENABLE,
  input  wire        EL1_SYSREG_IFACE_ENABLE,
  input  wire        EL2_PRESENT,
  input  wire        EL2_IS_32BIT,
  input  wire        CP_GROUP12_HYP_TRAP,
  input  wire        TRAP_ALL_GROUP1,
  input  wire        TRAP_ALL_GROUP0,
  // Access outcome.
  output wire        RSP_VALID,
  output wire        RSP_CLAIMED,
  output wire [31:0] RSP_RDATA,
  output wire        RSP_UNDEF,
  output wire        RSP_TRAP_EL1,
  output wire        RSP_TRAP_EL2,
  output wire        RSP_TRAP_HYP,
  // Forwarding to the physical registers.
  output wire        RSP_TO_PHYS,
  output wire        RSP_PHYS_BP0,
  output wire [1:0]  RSP_PHYS_INDEX,
  // Group 0 preemption split for the prioritisation logic.
  output wire [2:0]  BP0_VALUE,
  output wire [7:0]  GROUP0_PREEMPT_MASK,
  output wire        GROUP0_PREEMPT_EN
);

  // Fewer priority bits leave the low priority bits unused, so the split
  // can never fall below them.
  localparam integer MIN_BP_I = 7 - PRIORITY_BIT_COUNT;
  localparam [2:0]   MIN_BP   = MIN_BP_I[2:0];

  // Common encoding check for both register kinds.
  function enc_base;
    input [2:0] opc1;
    input [3:0] crn;
    input [3:0] cop;
    begin
      enc_base = (opc1 == `VCP_OPC1) && (crn == `VCP_CRN) && (cop == `VCP_COPROC);
    end
  endfunction

  // Which active priority indices exist at this priority bit count.
  function idx_impl;
    input [1:0] idx;
    begin
      case (idx)
        2'd0:    idx_impl = 1'b1;
        2'd1:    idx_impl = (PRIORITY_BIT_COUNT >= `VCP_PRI_BITS_FOR_AP1);
        default: idx_impl = (PRIORITY_BIT_COUNT >= `VCP_PRI_BITS_FOR_AP2);
      endcase
    end
  endfunction

  // Outcome codes of one access.
  localparam [2:0] OUT_NONE  = 3'd0;
  localparam [2:0] OUT_PHYS  = 3'd1;
  localparam [2:0] OUT_UNDEF = 3'd2;
  localparam [2:0] OUT_TEL1  = 3'd3;
  localparam [2:0] OUT_TEL2  = 3'd4;
  localparam [2:0] OUT_VIRT  = 3'd5;

  wire        base_ok = enc_base(ACC_OPC1, ACC_CRN, ACC_COPROC);
  wire        hit_ap  = ACC_VALID && base_ok && (ACC_CRM == `VCP_CRM_AP1) &&
                        (ACC_OPC2[2] == `VCP_AP1_OPC2_TOP);
  wire        hit_bp  = ACC_VALID && base_ok && (ACC_CRM == `VCP_CRM_BP0) &&
                        (ACC_OPC2 == `VCP_OPC2_BP0);
  wire [1:0]  ap_idx  = ACC_OPC2[1:0];
  wire        el1_ns  = NONSECURE_SELECT && (ACC_EL == `VCP_EL1);
  wire        route   = hit_ap ? IRQ_ROUTE_TO_HYP : FIQ_ROUTE_TO_HYP;
  wire        tall    = hit_ap ? TRAP_ALL_GROUP1 : TRAP_ALL_GROUP0;
  // Only Non-secure EL1 with routing set and trap-general clear sees the virtual copy.
  wire        virt    = el1_ns && route && !TRAP_GENERAL_TO_HYP;

  reg  [2:0]  outcome;
  reg         hyp_mode;

  // Decision order, first match wins. An encoding that is not ours stays
  // unclaimed, and EL0 is always undefined. Anything but Non-secure EL1 with
  // its routing bit set and trap-general clear goes to the physical copy.
  // After that come the two interface enables, the group 12 trap and the
  // trap-all bit. The index check comes last, so that a trap is never hidden
  // behind an undefined answer for a register the guest cannot reach anyway.
  // Forwarded accesses are not checked for index here; the physical side owns that.
  always @* begin
    outcome  = OUT_NONE;
    hyp_mode = 1'b0;
    if (!(hit_ap || hit_bp)) begin
      outcome = OUT_NONE;
    end else if (ACC_EL == `VCP_EL0) begin
      outcome = OUT_UNDEF;
    end else if (!virt) begin
      outcome = OUT_PHYS;
    end else if (!SYSREG_IFACE_ENABLE) begin
      outcome = OUT_UNDEF;
    end else if (!EL1_SYSREG_IFACE_ENABLE) begin
      outcome = OUT_TEL1;
    end else if (EL2_PRESENT && CP_GROUP12_HYP_TRAP &&
                 (!EL2_IS_32BIT || NONSECURE_SELECT)) begin
      outcome = OUT_TEL2;
      hyp_mode = EL2_IS_32BIT;
    end else if (NONSECURE_SELECT && tall) begin
      outcome = OUT_TEL2;
    end else if (hit_ap && !idx_impl(ap_idx)) begin
      outcome = OUT_UNDEF;
    end else begin
      outcome = OUT_VIRT;
    end
  end

  // Only a virtual access may change state; forwarded and trapped writes store nothing.
  wire        do_write = (outcome == OUT_VIRT) && ACC_WRITE;

  // Active priority words; indices that do not exist read as zero and
  // cost no flops. Software is trusted to restore only values it read.
  wire [31:0] ap_val [0:`VCP_NUM_AP-1];
  genvar gi;
  generate
    for (gi = 0; gi < `VCP_NUM_AP; gi = gi + 1) begin : g_ap
      if ((gi == 0) ||
          ((gi == 1) && (PRIORITY_BIT_COUNT >= `VCP_PRI_BITS_FOR_AP1)) ||
          ((gi >= 2) && (PRIORITY_BIT_COUNT >= `VCP_PRI_BITS_FOR_AP2))) begin : g_impl
        reg [31:0] ap_q;
        always @(posedge CLOCK) begin
          if (SYS_RST) begin
            ap_q <= `VCP_AP_RESET;
          end else if (CE && do_write && hit_ap && (ap_idx == gi)) begin
            ap_q <= ACC_WDATA;
          end
        end
        assign ap_val[gi] = ap_q;
      end else begin : g_none
        assign ap_val[gi] = `VCP_AP_RESET;
      end
    end
  endgenerate

  // Binary point with saturation at the minimum.
  reg  [2:0]  bp_q;
  wire [2:0]  bp_wr  = ACC_WDATA[`VCP_BP_MSB:0];
  wire [2:0]  bp_d   = (bp_wr < MIN_BP) ? MIN_BP : bp_wr;

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      bp_q <= MIN_BP;
    end else if (CE && do_write && hit_bp) begin
      bp_q <= bp_d;
    end
  end

  wire [7:0]  mask_w;
  wire        pen_w;

  vcp_bpr_split u_split (
    .BP         (bp_q),
    .GROUP_MASK (mask_w),
    .PREEMPT_EN (pen_w)
  );

  // Read data: reserved bits of the binary point read as zero.
  wire [31:0] rd_sel  = hit_ap ? ap_val[ap_idx] : {29'h0, bp_q};

  // Response registers.
  reg         valid_q;
  reg         claimed_q;
  reg  [31:0] rdata_q;
  reg         undef_q;
  reg         tel1_q;
  reg         tel2_q;
  reg         hyp_q;
  reg         phys_q;
  reg         phys_bp_q;
  reg  [1:0]  phys_idx_q;
  reg  [7:0]  mask_q;
  reg         pen_q;

  // Next values of the response registers. With no request all but the split mask and enable fall
  // to zero, so a stale answer never looks like a fresh one.
  reg         valid_d;
  reg         claimed_d;
  reg  [31:0] rdata_d;
  reg         undef_d;
  reg         tel1_d;
  reg         tel2_d;
  reg         hyp_d;
  reg         phys_d;
  reg         phys_bp_d;
  reg  [1:0]  phys_idx_d;
  reg  [7:0]  mask_d;
  reg         pen_d;

  always @* begin
    valid_d    = ACC_VALID;
    claimed_d  = (outcome != OUT_NONE);
    rdata_d    = 32'h00000000;
    if ((outcome == OUT_VIRT) && !ACC_WRITE) begin
      rdata_d  = rd_sel;
    end
    undef_d    = (outcome == OUT_UNDEF);
    tel1_d     = (outcome == OUT_TEL1);
    tel2_d     = (outcome == OUT_TEL2);
    hyp_d      = (outcome == OUT_TEL2) && hyp_mode;
    phys_d     = (outcome == OUT_PHYS);
    phys_bp_d  = hit_bp;
    phys_idx_d = hit_ap ? ap_idx : 2'h0;
    // The split lags the binary point by one enabled edge to stay a plain flop output.
    mask_d     = mask_w;
    pen_d      = pen_w;
  end

  // Reset wins over a low clock enable so the block always starts clean.
  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      valid_q    <= 1'b0;
      claimed_q  <= 1'b0;
      rdata_q    <= 32'h00000000;
      undef_q    <= 1'b0;
      tel1_q     <= 1'b0;
      tel2_q     <= 1'b0;
      hyp_q      <= 1'b0;
      phys_q     <= 1'b0;
      phys_bp_q  <= 1'b0;
      phys_idx_q <= 2'h0;
      mask_q     <= 8'h00;
      pen_q      <= 1'b0;
    end else if (CE) begin
      valid_q    <= valid_d;
      claimed_q  <= claimed_d;
      rdata_q    <= rdata_d;
      undef_q    <= undef_d;
      tel1_q     <= tel1_d;
      tel2_q     <= tel2_d;
      hyp_q      <= hyp_d;
      phys_q     <= phys_d;
      phys_bp_q  <= phys_bp_d;
      phys_idx_q <= phys_idx_d;
      mask_q     <= mask_d;
      pen_q      <= pen_d;
    end
  end

  assign RSP_VALID           = valid_q;
  assign RSP_CLAIMED         = claimed_q;
  assign RSP_RDATA           = rdata_q;
  assign RSP_UNDEF           = undef_q;
  assign RSP_TRAP_EL1        = tel1_q;
  assign RSP_TRAP_EL2        = tel2_q;
  assign RSP_TRAP_HYP        = hyp_q;
  assign RSP_TO_PHYS         = phys_q;
  assign RSP_PHYS_BP0        = phys_bp_q;
  assign RSP_PHYS_INDEX      = phys_idx_q;
  assign BP0_VALUE           = bp_q;
  assign GROUP0_PREEMPT_MASK = mask_q;
  assign GROUP0_PREEMPT_EN   = pen_q;

endmodule
`default_nettype wire

//--- vcp_map.vh
// Constants for the virtual priority system register block.
`ifndef VCP_MAP_VH
`define VCP_MAP_VH

// Access encoding shared by both register kinds.
`define VCP_OPC1            3'b000
`define VCP_CRN             4'b1100
`define VCP_COPROC          4'b1111
// Group 1 active priorities: opc2 is 0 followed by the index.
`define VCP_CRM_AP1         4'b1001
`define VCP_AP1_OPC2_TOP    1'b0
// Group 0 binary point.
`define VCP_CRM_BP0         4'b1000
`define VCP_OPC2_BP0        3'b011

// Exception levels as presented on the access port.
`define VCP_EL0             2'b00
`define VCP_EL1             2'b01

// Field layout and reset values.
`define VCP_BP_MSB          2
`define VCP_AP_RESET        32'h00000000
`define VCP_NUM_AP          4
`define VCP_PRI_BITS_DEFAULT 5
`define VCP_PRI_BITS_FOR_AP1 6
`define VCP_PRI_BITS_FOR_AP2 7
`define VCP_BP_NO_PREEMPT   3'h7

`endif

//--- vcp_bpr_split.v
// Splits an 8-bit priority into preemption group and subpriority by binary point.
`timescale 1ns/1ps
`default_nettype none
`include "vcp_map.vh"

module vcp_bpr_split (
  // Binary point field.
  input  wire [2:0] BP,
  // Bits set where the priority belongs to the preemption group.
  output reg  [7:0] GROUP_MASK,
  // Low when the group performs no preemption at all.
  output reg        PREEMPT_EN
);

  reg [8:0] shifted;

  always @* begin
    // Bits 7 down to bp+1 are group bits; bp down to 0 are subpriority.
    shifted = 9'h1ff << ({1'b0, BP} + 4'h1);
    GROUP_MASK = shifted[7:0];
    PREEMPT_EN = (BP != `VCP_BP_NO_PREEMPT);
  end

endmodule
`default_nettype wire

//--- vcp_sysregs_monitor.sv
// Assertion checker for the virtual priority system register block.
`timescale 1ns/1ps
`default_nettype none
module vcp_sysregs_monitor #(parameter integer PRIORITY_BIT_COUNT = 5) (
  // Clock, reset and access.
  input wire logic CLOCK, SYS_RST, CE, ACC_VALID,
  input wire logic [2:0] ACC_OPC1, ACC_OPC2,
  input wire logic [3:0] ACC_CRN, ACC_CRM, ACC_COPROC,
  input wire logic [1:0] ACC_EL,
  // Routing and traps.
  input wire logic NONSECURE_SELECT, IRQ_ROUTE_TO_HYP, FIQ_ROUTE_TO_HYP, TRAP_GENERAL_TO_HYP,
  input wire logic SYSREG_IFACE_ENABLE, EL1_SYSREG_IFACE_ENABLE, EL2_PRESENT,
  input wire logic CP_GROUP12_HYP_TRAP, TRAP_ALL_GROUP1, TRAP_ALL_GROUP0,
  // Outcome and split.
  input wire logic RSP_VALID, RSP_CLAIMED, RSP_UNDEF, RSP_TRAP_EL1, RSP_TRAP_EL2,
  input wire logic RSP_TO_PHYS, RSP_PHYS_BP0, GROUP0_PREEMPT_EN,
  input wire logic [2:0] BP0_VALUE,
  input wire logic [7:0] GROUP0_PREEMPT_MASK
);
  localparam logic [2:0] MIN_BP = 3'(7 - PRIORITY_BIT_COUNT);
  localparam int NUM_AP = PRIORITY_BIT_COUNT >= 7 ? 4 : PRIORITY_BIT_COUNT >= 6 ? 2 : 1;
  wire logic req = ACC_VALID && CE;
  wire logic enc = ACC_OPC1 == 3'h0 && ACC_CRN == 4'hc && ACC_COPROC == 4'hf;
  wire logic ap = enc && ACC_CRM == 4'h9 && !ACC_OPC2[2];
  wire logic bp = enc && ACC_CRM == 4'h8 && ACC_OPC2 == 3'h3;
  wire logic ns1 = ACC_EL == 2'h1 && NONSECURE_SELECT && !TRAP_GENERAL_TO_HYP;
  wire logic va = req && ap && ns1 && IRQ_ROUTE_TO_HYP;
  wire logic vb = req && bp && ns1 && FIQ_ROUTE_TO_HYP;
  wire logic en = SYSREG_IFACE_ENABLE && EL1_SYSREG_IFACE_ENABLE;
  wire logic ok = en && !(EL2_PRESENT && CP_GROUP12_HYP_TRAP);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // The split register follows the binary point at the next enabled edge.
  sequence s_bp_settled;
    CE ##1 1'b1;
  endsequence
  chk_answer_next: assert property (req |=> RSP_VALID && RSP_CLAIMED == $past(ap || bp))
    else $error("access answer missing or wrong");
  chk_irq_phys: assert property (req && ap && ACC_EL == 2'h1 && NONSECURE_SELECT &&
    !IRQ_ROUTE_TO_HYP |=> RSP_TO_PHYS && !RSP_PHYS_BP0) else $error("group 1 not sent on");
  chk_el0_undef: assert property (req && (ap || bp) && ACC_EL == 2'h0 |=> RSP_UNDEF)
    else $error("lowest level access not undefined");
  chk_fiq_phys: assert property (req && bp && ACC_EL == 2'h1 && NONSECURE_SELECT &&
    !FIQ_ROUTE_TO_HYP |=> RSP_TO_PHYS && RSP_PHYS_BP0) else $error("point not sent on");
  chk_iface_undef: assert property ((va || vb) && !SYSREG_IFACE_ENABLE |=> RSP_UNDEF)
    else $error("disabled interface not undefined");
  chk_el1_trap: assert property ((va || vb) && SYSREG_IFACE_ENABLE &&
    !EL1_SYSREG_IFACE_ENABLE |=> RSP_TRAP_EL1 && !RSP_UNDEF) else $error("no trap to EL1");
  chk_hyp_trap: assert property ((va || vb) && en && EL2_PRESENT && CP_GROUP12_HYP_TRAP
    |=> RSP_TRAP_EL2) else $error("no trap to EL2");
  chk_trap_all: assert property ((va && TRAP_ALL_GROUP1 || vb && TRAP_ALL_GROUP0) && ok
    |=> RSP_TRAP_EL2) else $error("trap all ignored");
  chk_index_undef: assert property (va && ok && !TRAP_ALL_GROUP1 &&
    int'(ACC_OPC2[1:0]) >= NUM_AP |=> RSP_UNDEF) else $error("missing index defined");
  chk_bp_floor: assert property (BP0_VALUE >= MIN_BP)
    else $error("point below minimum");
  chk_bp_reset: assert property ($past(SYS_RST) |-> BP0_VALUE == MIN_BP)
    else $error("point reset wrong");
  chk_mask_split: assert property (s_bp_settled |->
    GROUP0_PREEMPT_MASK == 8'hff << ($past(BP0_VALUE) + 1) &&
    GROUP0_PREEMPT_EN == ($past(BP0_VALUE) != 3'h7)) else $error("split wrong");
endmodule
bind vcp_sysregs vcp_sysregs_monitor #(.PRIORITY_BIT_COUNT(PRIORITY_BIT_COUNT)) mon (.*);
`default_nettype wire

//--- vcp_core_model.sv
// Processor core model issuing system register instructions.
`timescale 1ns/1ps
`default_nettype none
module vcp_core_model (
  input wire logic CLOCK,
  output logic ACC_VALID, ACC_WRITE,
  output logic [2:0] ACC_OPC1, ACC_OPC2,
  output logic [3:0] ACC_CRN, ACC_CRM, ACC_COPROC,
  output logic [1:0] ACC_EL,
  output logic [31:0] ACC_WDATA
);
  initial {ACC_VALID, ACC_WRITE, ACC_OPC1, ACC_OPC2, ACC_CRN, ACC_CRM, ACC_COPROC} = '0;
  initial {ACC_EL, ACC_WDATA} = '0;
  task automatic acc(input logic w, input logic [3:0] cop, crm, input logic [2:0] op2,
                     input logic [1:0] el, input logic [31:0] wd);
    @(posedge CLOCK);
    #1;
    ACC_VALID = 1'b1;
    ACC_WRITE = w;
    ACC_OPC1 = 3'h0;
    ACC_CRN = 4'hc;
    {ACC_COPROC, ACC_CRM, ACC_OPC2, ACC_EL, ACC_WDATA} = {cop, crm, op2, el, wd};
    @(posedge CLOCK);
    #1;
    // Released data and CRm fields are scrambled so no stale value looks valid.
    ACC_VALID = 1'b0;
    ACC_WDATA = ~wd;
    ACC_CRM = ~crm;
  endtask
endmodule
`default_nettype wire

//--- vcp_sysregs_tb.sv
// Self-checking testbench for the virtual priority system register block.
`timescale 1ns/1ps
`default_nettype none
module vcp_sysregs_tb;
  localparam integer PBITS = 6;
  localparam int MINBP = 7 - PBITS;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [10:0] ctl = 11'h760;
  logic CE = 1'b1;
  wire logic ACC_VALID, ACC_WRITE, NONSECURE_SELECT, IRQ_ROUTE_TO_HYP, FIQ_ROUTE_TO_HYP;
  wire logic TRAP_GENERAL_TO_HYP, SYSREG_IFACE_ENABLE, EL1_SYSREG_IFACE_ENABLE, EL2_PRESENT;
  wire logic EL2_IS_32BIT, CP_GROUP12_HYP_TRAP, TRAP_ALL_GROUP1, TRAP_ALL_GROUP0;
  wire logic [2:0] ACC_OPC1, ACC_OPC2, BP0_VALUE;
  wire logic [3:0] ACC_CRN, ACC_CRM, ACC_COPROC;
  wire logic [1:0] ACC_EL, RSP_PHYS_INDEX;
  wire logic [31:0] ACC_WDATA, RSP_RDATA;
  wire logic RSP_VALID, RSP_CLAIMED, RSP_UNDEF, RSP_TRAP_EL1, RSP_TRAP_EL2, RSP_TRAP_HYP;
  wire logic RSP_TO_PHYS, RSP_PHYS_BP0, GROUP0_PREEMPT_EN;
  wire logic [7:0] GROUP0_PREEMPT_MASK;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  assign {NONSECURE_SELECT, IRQ_ROUTE_TO_HYP, FIQ_ROUTE_TO_HYP, TRAP_GENERAL_TO_HYP,
          SYSREG_IFACE_ENABLE, EL1_SYSREG_IFACE_ENABLE, EL2_PRESENT, EL2_IS_32BIT,
          CP_GROUP12_HYP_TRAP, TRAP_ALL_GROUP1, TRAP_ALL_GROUP0} = ctl;
  always #4 CLOCK = ~CLOCK;
  vcp_core_model core (.*);
  vcp_sysregs #(.PRIORITY_BIT_COUNT(PBITS)) uut (.*);
  task automatic chk(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      conclude();
    end
  end
  // Outcome as {undefined, trap EL1, trap EL2, hyp, physical}.
  task automatic rt(input logic b, input logic [1:0] el, input logic [10:0] c, input logic [4:0] e);
    ctl = c;
    core.acc(1'b0, 4'hf, b ? 4'h8 : 4'h9, b ? 3'h3 : 3'h0, el, 32'h0);
    chk({RSP_UNDEF, RSP_TRAP_EL1, RSP_TRAP_EL2, RSP_TRAP_HYP, RSP_TO_PHYS}, e);
    ctl = 11'h760;
  endtask
  initial begin
    int e;
    repeat (10) @(posedge CLOCK);
    #1 SYS_RST = 1'b0;
    chk(BP0_VALUE, MINBP);
    for (int n = 0; n < 4; n++) begin
      if (n < 2) core.acc(1'b1, 4'hf, 4'h9, n[2:0], 2'h1, 32'h0);
      core.acc(1'b0, 4'hf, 4'h9, n[2:0], 2'h1, 32'h0);
      chk(RSP_CLAIMED, 1);
      chk(RSP_UNDEF, n >= 2);
      chk(RSP_RDATA, 0);
      chk(RSP_PHYS_INDEX, n);
      chk(RSP_VALID, 1);
    end
    $display("active priority test done");
    for (int v = 0; v < 8; v++) begin
      e = v < MINBP ? MINBP : v;
      core.acc(1'b1, 4'hf, 4'h8, 3'h3, 2'h1, 32'hfffffff8 | v);
      core.acc(1'b0, 4'hf, 4'h8, 3'h3, 2'h1, 32'h0);
      chk(RSP_RDATA, e);
      chk(GROUP0_PREEMPT_MASK, (32'hff << (e + 1)) & 32'hff);
      chk(GROUP0_PREEMPT_EN, e != 7);
    end
    ctl = 11'h660;
    core.acc(1'b1, 4'hf, 4'h8, 3'h3, 2'h1, 32'h3);
    ctl = 11'h760;
    core.acc(1'b0, 4'hf, 4'h8, 3'h3, 2'h1, 32'h0);
    chk(RSP_RDATA, 7);
    // A write offered while the clock enable is low must not be taken.
    CE = 1'b0;
    core.acc(1'b1, 4'hf, 4'h8, 3'h3, 2'h1, 32'h4);
    chk(BP0_VALUE, 7);
    chk(RSP_RDATA, 7);
    CE = 1'b1;
    core.acc(1'b0, 4'hf, 4'h8, 3'h3, 2'h1, 32'h0);
    chk(RSP_RDATA, 7);
    $display("binary point test done");
    rt(0, 2'h1, 11'h760, 5'h00);
    rt(0, 2'h0, 11'h760, 5'h10);
    rt(1, 2'h0, 11'h760, 5'h10);
    rt(0, 2'h2, 11'h760, 5'h01);
    rt(0, 2'h1, 11'h360, 5'h01);
    rt(0, 2'h1, 11'h7e0, 5'h01);
    rt(0, 2'h1, 11'h560, 5'h01);
    rt(0, 2'h1, 11'h660, 5'h00);
    rt(1, 2'h1, 11'h660, 5'h01);
    rt(1, 2'h1, 11'h560, 5'h00);
    rt(1, 2'h3, 11'h760, 5'h01);
    rt(0, 2'h1, 11'h720, 5'h10);
    rt(1, 2'h1, 11'h740, 5'h08);
    rt(0, 2'h1, 11'h774, 5'h04);
    rt(1, 2'h1, 11'h77c, 5'h06);
    rt(0, 2'h1, 11'h762, 5'h04);
    rt(0, 2'h1, 11'h761, 5'h00);
    rt(1, 2'h1, 11'h761, 5'h04);
    rt(1, 2'h1, 11'h762, 5'h00);
    core.acc(1'b0, 4'he, 4'h9, 3'h0, 2'h1, 32'h0);
    chk(RSP_CLAIMED, 0);
    $display("routing test done");
    conclude();
  end
endmodule
`default_nettype wire
